// ### txd_defs.svh
// Register map, field positions and reset values of the transmit driver and status bank
// How it works
// - Bit-rate detection result in status bits 5:4
// - Bits 3/2 show passive power and general timers
// - Bit 1 follows no-response timer running
// - Bit 0 follows mask receive timer running
// - Last conversion result readable at 25h
// - 26h and 27h read zero, read-only
// - Modulation index code maps to percent table
// - Resistance code maps to undefined/unit/double/quad/high-Z
// - Transmit driver register resets to 70h
// - Aux bit 7 low enables regulator AM
// - Aux bit 6 selects external pin polarity
// - Aux bit 5 gates external pin, reset clear
// - Aux bit 4 driver load modulation, reset set
// - Aux bit 3 resistive AM using 7-bit setting
`ifndef TXD_DEFS_SVH
`define TXD_DEFS_SVH

// Word indices; byte address is four times the index
`define TXD_IDX_STATUS     8'h24
`define TXD_IDX_CONV       8'h25
`define TXD_IDX_RSVD0      8'h26
`define TXD_IDX_RSVD1      8'h27
`define TXD_IDX_DRIVER     8'h28
`define TXD_IDX_AUX        8'ha8

`define TXD_RST_DRIVER     8'h70
`define TXD_RST_AUX        8'h10
`define TXD_RSVD_VALUE     8'h00

// Status fields
`define TXD_ST_RATE_HI     5
`define TXD_ST_RATE_LO     4
`define TXD_ST_PPT         3
`define TXD_ST_GPT         2
`define TXD_ST_NRT         1
`define TXD_ST_MRT         0

// Transmit driver fields
`define TXD_DRV_MOD_HI     7
`define TXD_DRV_MOD_LO     4
`define TXD_DRV_RES_HI     3
`define TXD_DRV_RES_LO     0

// Auxiliary modulation fields
`define TXD_AUX_REG_AM_DIS 7
`define TXD_AUX_EXT_POL    6
`define TXD_AUX_EXT_EN     5
`define TXD_AUX_DRV_LM     4
`define TXD_AUX_RESISTIVE_AM_ENABLE     3
`define TXD_AUX_MASK       8'hf8

// Modulation index table
`define TXD_PCT_BASE       7'h05
`define TXD_PCT_LIN_MAX    4'ha
`define TXD_PCT_C11        7'h11
`define TXD_PCT_C12        7'h13
`define TXD_PCT_C13        7'h16
`define TXD_PCT_C14        7'h1a
`define TXD_PCT_C15        7'h28

// Resistance code thresholds
`define TXD_RES_UNIT       4'h2
`define TXD_RES_DBL_MAX    4'h4
`define TXD_RES_QUAD_MAX   4'he
`define TXD_RES_HIGHZ      4'hf

`define TXD_STAT_W         6
`endif

// ### txd_pkg.sv
// Types shared by the transmit driver and status bank
package txd_pkg;
  typedef enum logic [2:0]
  {
    TXD_RES_UNDEF  = 3'h0,
    TXD_RES_UNIT   = 3'h1,
    TXD_RES_DOUBLE = 3'h2,
    TXD_RES_QUAD   = 3'h3,
    TXD_RES_HIGHZ  = 3'h4
  } txd_res_e;

  typedef enum logic [0:0]
  {
    TXD_BUS_IDLE = 1'h0,
    TXD_BUS_ACK  = 1'h1
  } txd_bus_e;

  typedef logic [7:0] txd_byte_t;
endpackage : txd_pkg

// ### txd_sync.sv
// Three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
module txd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_sync_out;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_comb
      begin
        next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end
endmodule : txd_sync

// ### txd_decode.sv
// Decodes modulation index and driver resistance codes into registered settings
`timescale 1ns/100ps
`include "txd_defs.svh"
module txd_decode (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [3:0]       mod_code,
  input  wire logic [3:0]       res_code,
  output logic      [6:0]       modulation_percent,
  output txd_pkg::txd_res_e     res_class
);
  logic [6:0]        next_modulation_percent;
  txd_pkg::txd_res_e next_res_class;

  function automatic logic [6:0] pct_of(input logic [3:0] c);
    unique case (c)
      4'hb:    pct_of = `TXD_PCT_C11;
      4'hc:    pct_of = `TXD_PCT_C12;
      4'hd:    pct_of = `TXD_PCT_C13;
      4'he:    pct_of = `TXD_PCT_C14;
      4'hf:    pct_of = `TXD_PCT_C15;
      default: pct_of = `TXD_PCT_BASE + {3'h0, c};
    endcase
  endfunction : pct_of

  function automatic txd_pkg::txd_res_e res_of(input logic [3:0] c);
    if (c == `TXD_RES_HIGHZ)
      res_of = txd_pkg::TXD_RES_HIGHZ;
    else if (c > `TXD_RES_DBL_MAX)
      res_of = txd_pkg::TXD_RES_QUAD;
    else if (c > `TXD_RES_UNIT)
      res_of = txd_pkg::TXD_RES_DOUBLE;
    else if (c == `TXD_RES_UNIT)
      res_of = txd_pkg::TXD_RES_UNIT;
    else
      res_of = txd_pkg::TXD_RES_UNDEF;
  endfunction : res_of

  always_comb
  begin
    next_modulation_percent = pct_of(mod_code);
    next_res_class          = res_of(res_code);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modulation_percent <= `TXD_PCT_BASE;
      res_class          <= txd_pkg::TXD_RES_UNDEF;
    end
    else
    begin
      modulation_percent <= next_modulation_percent;
      res_class          <= next_res_class;
    end
  end
endmodule : txd_decode

// ### txd_regs.sv
// Transmit driver and status register bank with Avalon-MM slave
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "txd_defs.svh"
module txd_regs (
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Avalon-MM slave, word addressed
  input  wire logic [7:0]   address,
  input  wire logic         read,
  input  wire logic         write,
  input  wire logic [31:0]  writedata,
  input  wire logic [3:0]   byteenable,
  output logic      [31:0]  readdata,
  output logic              waitrequest,
  // Status sources from other domains
  input  wire logic [1:0]   detected_rate,
  input  wire logic         passive_power_timer_running,
  input  wire logic         general_timer_running,
  input  wire logic         no_response_timer_running,
  input  wire logic         mask_receive_timer_running,
  input  wire logic [7:0]   conversion_data,
  input  wire logic         conversion_done_toggle,
  // Same-clock modulation sources
  input  wire logic         load_mod_signal,
  input  wire logic [6:0]   resistive_am_resistance,
  input  wire logic [3:0]   target_modulated_resistance,
  input  wire logic [3:0]   target_unmodulated_resistance,
  // Driver controls
  output logic [3:0]        modulation_index_code,
  output logic [6:0]        modulation_percent,
  output logic [3:0]        driver_resistance_code,
  output txd_pkg::txd_res_e driver_resistance_class,
  output logic              rf_output_driver_highz,
  output logic              regulator_am_enable,
  output logic              driver_load_mod_enable,
  output logic              resistive_am_enable,
  output logic [6:0]        resistive_am_setting,
  output logic [3:0]        load_mod_resistance,
  output logic              external_load_mod_pin
);
  // Synchronised status; conversion toggle has its own synchroniser
  logic [`TXD_STAT_W-1:0] stat_raw;
  logic [`TXD_STAT_W-1:0] stat_sync;
  logic [7:0]             conv_data_s1;
  logic [7:0]             conv_data_s2;
  logic                   conv_tog_sync;
  logic                   conv_tog_seen;
  logic                   next_conv_tog_seen;

  // Registers
  txd_pkg::txd_byte_t     driver_reg;
  txd_pkg::txd_byte_t     aux_reg;
  txd_pkg::txd_byte_t     conv_reg;
  txd_pkg::txd_byte_t     next_driver_reg;
  txd_pkg::txd_byte_t     next_aux_reg;
  txd_pkg::txd_byte_t     next_conv_reg;

  // Bus state
  txd_pkg::txd_bus_e      bus_state;
  txd_pkg::txd_bus_e      next_bus_state;
  logic [31:0]            next_readdata;
  logic                   req;
  logic                   wr_take;

  // Output registers
  logic                   next_regulator_am_enable;
  logic                   next_driver_load_mod_enable;
  logic                   next_resistive_am_enable;
  logic [6:0]             next_resistive_am_setting;
  logic [3:0]             next_load_mod_resistance;
  logic                   next_external_load_mod_pin;
  logic                   next_rf_output_driver_highz;

  function automatic txd_pkg::txd_byte_t read_mux(
    input logic [7:0]         idx,
    input logic [`TXD_STAT_W-1:0] st,
    input txd_pkg::txd_byte_t cv,
    input txd_pkg::txd_byte_t dr,
    input txd_pkg::txd_byte_t ax
  );
    unique case (idx)
      `TXD_IDX_STATUS: read_mux = {2'h0, st};
      `TXD_IDX_CONV:   read_mux = cv;
      `TXD_IDX_RSVD0:  read_mux = `TXD_RSVD_VALUE;
      `TXD_IDX_RSVD1:  read_mux = `TXD_RSVD_VALUE;
      `TXD_IDX_DRIVER: read_mux = dr;
      `TXD_IDX_AUX:    read_mux = ax;
      default:         read_mux = 8'h00;
    endcase
  endfunction : read_mux

  assign stat_raw[`TXD_ST_RATE_HI:`TXD_ST_RATE_LO] = detected_rate;
  assign stat_raw[`TXD_ST_PPT]                      = passive_power_timer_running;
  assign stat_raw[`TXD_ST_GPT]                      = general_timer_running;
  assign stat_raw[`TXD_ST_NRT]                      = no_response_timer_running;
  assign stat_raw[`TXD_ST_MRT]                      = mask_receive_timer_running;

  txd_sync #(
    .W (`TXD_STAT_W)
  ) u_stat_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (stat_raw),
    .sync_out (stat_sync)
  );

  // Event crossing: data is held stable by the converter across its toggle
  txd_sync #(
    .W (1)
  ) u_conv_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (conversion_done_toggle),
    .sync_out (conv_tog_sync)
  );

  txd_decode u_decode (
    .clk                (clk),
    .arst_n             (arst_n),
    .mod_code           (driver_reg[`TXD_DRV_MOD_HI:`TXD_DRV_MOD_LO]),
    .res_code           (driver_reg[`TXD_DRV_RES_HI:`TXD_DRV_RES_LO]),
    .modulation_percent (modulation_percent),
    .res_class          (driver_resistance_class)
  );

  // One wait cycle on every access, so a read answer always comes from a flop
  assign req         = read | write;
  assign waitrequest = req & (bus_state == txd_pkg::TXD_BUS_IDLE);
  assign wr_take     = write & (bus_state == txd_pkg::TXD_BUS_ACK) & byteenable[0];

  always_comb
  begin
    next_bus_state = txd_pkg::TXD_BUS_IDLE;
    next_readdata  = readdata;
    unique case (bus_state)
      txd_pkg::TXD_BUS_IDLE:
      begin
        if (req)
        begin
          next_bus_state = txd_pkg::TXD_BUS_ACK;
          if (read)
            next_readdata = {24'h0, read_mux(address, stat_sync, conv_reg,
                                             driver_reg, aux_reg)};
        end
      end
      txd_pkg::TXD_BUS_ACK:
      begin
        next_bus_state = txd_pkg::TXD_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_state <= txd_pkg::TXD_BUS_IDLE;
      readdata  <= 32'h0;
    end
    else
    begin
      bus_state <= next_bus_state;
      readdata  <= next_readdata;
    end
  end

  // Register writes; read-only and unmapped indices fall through untouched
  always_comb
  begin
    next_driver_reg = driver_reg;
    next_aux_reg    = aux_reg;
    if (wr_take)
    begin
      if (address == `TXD_IDX_DRIVER)
        next_driver_reg = writedata[7:0];
      else if (address == `TXD_IDX_AUX)
        next_aux_reg = writedata[7:0] & `TXD_AUX_MASK; // Spare bits stay zero
    end
  end

  // Capture conversion result on a completed-conversion event
  always_comb
  begin
    next_conv_tog_seen = conv_tog_sync;
    next_conv_reg      = conv_reg;
    if (conv_tog_sync != conv_tog_seen)
      next_conv_reg = conv_data_s2;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      driver_reg    <= `TXD_RST_DRIVER;
      aux_reg       <= `TXD_RST_AUX;
      conv_reg      <= 8'h00;
      conv_tog_seen <= 1'b0;
      conv_data_s1  <= 8'h00;
      conv_data_s2  <= 8'h00;
    end
    else
    begin
      driver_reg    <= next_driver_reg;
      aux_reg       <= next_aux_reg;
      conv_reg      <= next_conv_reg;
      conv_tog_seen <= next_conv_tog_seen;
      conv_data_s1  <= conversion_data;
      conv_data_s2  <= conv_data_s1;
    end
  end

  assign modulation_index_code  = driver_reg[`TXD_DRV_MOD_HI:`TXD_DRV_MOD_LO];
  assign driver_resistance_code = driver_reg[`TXD_DRV_RES_HI:`TXD_DRV_RES_LO];

  // Driver control outputs
  always_comb
  begin
    next_regulator_am_enable    = ~aux_reg[`TXD_AUX_REG_AM_DIS];
    next_driver_load_mod_enable = aux_reg[`TXD_AUX_DRV_LM];
    next_resistive_am_enable    = aux_reg[`TXD_AUX_RESISTIVE_AM_ENABLE];
    next_resistive_am_setting   = aux_reg[`TXD_AUX_RESISTIVE_AM_ENABLE] ?
                                  resistive_am_resistance : 7'h00;
    next_rf_output_driver_highz =
      (driver_reg[`TXD_DRV_RES_HI:`TXD_DRV_RES_LO] == `TXD_RES_HIGHZ);
    // Target resistances are trusted stable once target mode is entered
    if (aux_reg[`TXD_AUX_DRV_LM])
      next_load_mod_resistance = load_mod_signal ? target_modulated_resistance
                                                 : target_unmodulated_resistance;
    else
      next_load_mod_resistance = driver_reg[`TXD_DRV_RES_HI:`TXD_DRV_RES_LO];
    // Disabled pin rests at its inactive level for the chosen polarity
    if (aux_reg[`TXD_AUX_EXT_EN])
      next_external_load_mod_pin = load_mod_signal ^
                                   aux_reg[`TXD_AUX_EXT_POL];
    else
      next_external_load_mod_pin = aux_reg[`TXD_AUX_EXT_POL];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regulator_am_enable    <= 1'b1;
      driver_load_mod_enable <= 1'b1;
      resistive_am_enable    <= 1'b0;
      resistive_am_setting   <= 7'h00;
      rf_output_driver_highz <= 1'b0;
      load_mod_resistance    <= 4'h0;
      external_load_mod_pin  <= 1'b0;
    end
    else
    begin
      regulator_am_enable    <= next_regulator_am_enable;
      driver_load_mod_enable <= next_driver_load_mod_enable;
      resistive_am_enable    <= next_resistive_am_enable;
      resistive_am_setting   <= next_resistive_am_setting;
      rf_output_driver_highz <= next_rf_output_driver_highz;
      load_mod_resistance    <= next_load_mod_resistance;
      external_load_mod_pin  <= next_external_load_mod_pin;
    end
  end
endmodule : txd_regs

// ### txd_regs_properties.sv
// Port-level checks for the transmit driver register bank
`timescale 1ns/100ps
module txd_check (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic [7:0]        address,
  input wire logic              read,
  input wire logic              write,
  input wire logic              waitrequest,
  input wire logic [31:0]       readdata,
  input wire logic [3:0]        modulation_index_code,
  input wire logic [6:0]        modulation_percent,
  input wire logic [3:0]        driver_resistance_code,
  input txd_pkg::txd_res_e      driver_resistance_class,
  input wire logic              rf_output_driver_highz,
  input wire logic              regulator_am_enable,
  input wire logic              driver_load_mod_enable,
  input wire logic              resistive_am_enable,
  input wire logic [6:0]        resistive_am_setting,
  input wire logic [6:0]        resistive_am_resistance,
  input wire logic [3:0]        load_mod_resistance,
  input wire logic              load_mod_signal,
  input wire logic [3:0]        target_modulated_resistance,
  input wire logic [3:0]        target_unmodulated_resistance
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_highz_code: assert property (
    1 |=> rf_output_driver_highz == $past(driver_resistance_code == 4'hf))
    else $error("high impedance flag does not follow resistance code");
  a_class_quad: assert property (
    (driver_resistance_code inside {[4'h5:4'he]}) |=>
    driver_resistance_class == txd_pkg::TXD_RES_QUAD)
    else $error("resistance class not quadruple");
  a_percent_linear: assert property (
    (modulation_index_code <= 4'ha) |=>
    modulation_percent == 7'h05 + {3'h0, $past(modulation_index_code)})
    else $error("linear modulation percent wrong");
  a_percent_top: assert property (
    (modulation_index_code == 4'hf) |=> modulation_percent == 7'h28)
    else $error("top modulation percent wrong");
  a_driver_readback: assert property (
    read && !waitrequest && address == 8'h28 |->
    readdata[7:0] == {modulation_index_code, driver_resistance_code})
    else $error("driver register read differs from its fields");
  a_rsvd_zero: assert property (
    read && !waitrequest && (address inside {8'h26, 8'h27}) |-> readdata == 32'h0)
    else $error("reserved location read not zero");
  a_regam_cause: assert property (
    $changed(regulator_am_enable) |-> $past(write && !waitrequest, 2))
    else $error("regulator modulation changed without a write");
  a_drvlm_cause: assert property (
    $changed(driver_load_mod_enable) |-> $past(write && !waitrequest, 2))
    else $error("driver load modulation changed without a write");
  a_resistive_sel: assert property (
    $past(arst_n) |->
    resistive_am_setting == (resistive_am_enable ? $past(resistive_am_resistance) : 7'h0))
    else $error("resistive setting wrong");
  a_lmres_select: assert property (
    driver_load_mod_enable && $past(arst_n) |->
    load_mod_resistance == ($past(load_mod_signal) ? $past(target_modulated_resistance)
                                                   : $past(target_unmodulated_resistance)))
    else $error("load modulation resistance wrong");

  c_write_done: cover property (write && !waitrequest);
  c_highz: cover property (rf_output_driver_highz);
  c_resistive: cover property (resistive_am_enable);
endmodule : txd_check

// ### tb_txd.sv
// Self-checking bench for the transmit driver register bank
`timescale 1ns/100ps
module tb;
  logic clk = 0, arst_n = 0, read = 0, write = 0, ld_sig = 0, done_tgl = 0;
  logic [7:0] address = 8'h00, conv = 8'h00, q;
  logic [31:0] wdata = 32'h0, readdata;
  logic [3:0] be = 4'h1, mod_code, res_code, lm_res;
  logic [1:0] rate = 2'h0;
  logic [3:0] tmr = 4'h0;
  logic [6:0] pct_o, ram_set;
  logic waitrequest, hz, reg_am, drv_lm, ram_en, pin;
  txd_pkg::txd_res_e cls_o;
  int bad_count = 0, checks_done = 0;

  always #2.5 clk = ~clk;

  txd_regs dut_u (.clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(wdata), .byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
    .detected_rate(rate), .passive_power_timer_running(tmr[3]), .general_timer_running(tmr[2]),
    .no_response_timer_running(tmr[1]), .mask_receive_timer_running(tmr[0]),
    .conversion_data(conv), .conversion_done_toggle(done_tgl), .load_mod_signal(ld_sig),
    .resistive_am_resistance(7'h5b), .target_modulated_resistance(4'h9),
    .target_unmodulated_resistance(4'h3), .modulation_index_code(mod_code),
    .modulation_percent(pct_o), .driver_resistance_code(res_code),
    .driver_resistance_class(cls_o), .rf_output_driver_highz(hz), .regulator_am_enable(reg_am),
    .driver_load_mod_enable(drv_lm), .resistive_am_enable(ram_en),
    .resistive_am_setting(ram_set), .load_mod_resistance(lm_res), .external_load_mod_pin(pin));

  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  // Request held until the edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    read <= !wr;
    write <= wr;
    wdata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    // Write lands and read data is taken at this same edge
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    // Idle edge so a following call never re-drives in one step
    @(posedge clk);
    if (n >= 20)
    begin
      bad_count++;
      complete_run();
    end
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask : rd

  function automatic logic [7:0] pct(input logic [3:0] c);
    case (c)
      4'hb: return 8'h11;
      4'hc: return 8'h13;
      4'hd: return 8'h16;
      4'he: return 8'h1a;
      4'hf: return 8'h28;
      default: return 8'h05 + {4'h0, c};
    endcase
  endfunction : pct

  function automatic logic [7:0] cls(input logic [3:0] c);
    if (c < 4'h2) return {5'h0, txd_pkg::TXD_RES_UNDEF};
    if (c == 4'h2) return {5'h0, txd_pkg::TXD_RES_UNIT};
    if (c <= 4'h4) return {5'h0, txd_pkg::TXD_RES_DOUBLE};
    if (c <= 4'he) return {5'h0, txd_pkg::TXD_RES_QUAD};
    return {5'h0, txd_pkg::TXD_RES_HIGHZ};
  endfunction : cls

  task automatic t_reset_vals();
    rd(8'h28, 8'h70, "driver reset");
    rd(8'ha8, 8'h10, "aux reset");
    chk("pin reset", 8'h00, {7'h0, pin});
    chk("drv lm reset", 8'h01, {7'h0, drv_lm});
    be <= 4'h0;
    bus(1'b1, 8'h28, 8'h00);
    be <= 4'h1;
    rd(8'h28, 8'h70, "masked write");
  endtask : t_reset_vals

  task automatic t_status();
    logic [5:0] p [2] = '{6'h2a, 6'h15};
    foreach (p[i])
    begin
      rate <= p[i][5:4];
      tmr <= p[i][3:0];
      conv <= {p[i], 2'h1};
      repeat (3) @(posedge clk);
      done_tgl <= ~done_tgl;
      repeat (12) @(posedge clk);
      rd(8'h24, {2'h0, p[i]}, "status");
      rd(8'h25, {p[i], 2'h1}, "conversion");
    end
  endtask : t_status

  // Ignored writes must leave every read-only read intact
  task automatic t_readonly();
    for (int a = 8'h24; a <= 8'h27; a++)
      bus(1'b1, a[7:0], 8'hff);
    bus(1'b1, 8'h30, 8'hff);
    rd(8'h24, 8'h15, "status after write");
    rd(8'h25, 8'h55, "conversion after write");
    rd(8'h26, 8'h00, "reserved first");
    rd(8'h27, 8'h00, "reserved second");
    rd(8'h30, 8'h00, "unmapped");
  endtask : t_readonly

  task automatic t_codes();
    for (int c = 0; c < 16; c++)
    begin
      bus(1'b1, 8'h28, {c[3:0], c[3:0]});
      repeat (2) @(posedge clk);
      chk("percent", pct(c[3:0]), {1'b0, pct_o});
      chk("class", cls(c[3:0]), {5'h0, cls_o});
      chk("highz", {7'h0, c == 15}, {7'h0, hz});
      chk("codes", {c[3:0], c[3:0]}, {mod_code, res_code});
    end
  endtask : t_codes

  task automatic t_aux();
    logic [7:0] v [6] = '{8'h00, 8'h60, 8'h40, 8'h28, 8'hff, 8'h30};
    foreach (v[i])
    begin
      ld_sig <= i[0];
      bus(1'b1, 8'ha8, v[i]);
      repeat (2) @(posedge clk);
      rd(8'ha8, v[i] & 8'hf8, "aux readback");
      chk("regulator am", {7'h0, ~v[i][7]}, {7'h0, reg_am});
      chk("ext pin", {7'h0, v[i][5] ? i[0] ^ v[i][6] : v[i][6]}, {7'h0, pin});
      chk("driver lm", {7'h0, v[i][4]}, {7'h0, drv_lm});
      chk("resistive", {v[i][3], v[i][3] ? 7'h5b : 7'h0}, {ram_en, ram_set});
      chk("lm res", v[i][4] ? (i[0] ? 8'h09 : 8'h03) : 8'h0f, {4'h0, lm_res});
    end
  endtask : t_aux

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    t_status();
    t_readonly();
    t_codes();
    t_aux();
    complete_run();
  end
endmodule : tb

bind txd_regs txd_check chk_u (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
  .write(write), .waitrequest(waitrequest), .readdata(readdata),
  .modulation_index_code(modulation_index_code), .modulation_percent(modulation_percent),
  .driver_resistance_code(driver_resistance_code),
  .driver_resistance_class(driver_resistance_class),
  .rf_output_driver_highz(rf_output_driver_highz), .regulator_am_enable(regulator_am_enable),
  .driver_load_mod_enable(driver_load_mod_enable), .resistive_am_enable(resistive_am_enable),
  .resistive_am_setting(resistive_am_setting), .resistive_am_resistance(resistive_am_resistance),
  .load_mod_resistance(load_mod_resistance), .load_mod_signal(load_mod_signal),
  .target_modulated_resistance(target_modulated_resistance),
  .target_unmodulated_resistance(target_unmodulated_resistance));
